// File: rtl/ita_consts.svh
// Constants for the indirect table access port: offsets, fields, reset values.
// Notes on behaviour
// RULE1: Select register bit 4 set to 1 asks for a read of the entry, 0 for a write.
// RULE2: The table selector picks 00 static, 01 VLAN, 10 dynamic table, 11 counters.
// RULE3: Bits 1 and 0 of the select register give bits 9 and 8 of the entry address.
// RULE4: The low address register gives bits 7 down to 0 of the entry address, fully read/write.
// RULE5: The top data register carries entry bits 68 to 64 and software may read and write it.
// RULE6: Bits 7 to 5 of the select register are reserved, read only, and read as zero.
// RULE7: Writing the low address register starts the access set up by the other registers.
`ifndef ITA_CONSTS_SVH
`define ITA_CONSTS_SVH

// ****************************************************************
// Register indices, byte address is four times the index
// ****************************************************************
`define ITA_IDX_CTRL_SELECT  8'h6E
`define ITA_IDX_ADDR_LOW     8'h6F
`define ITA_IDX_DATA_TOP     8'h70
`define ITA_IDX_STATUS       8'h7E

// ****************************************************************
// Bus and field layout
// ****************************************************************
`define ITA_BUS_AW           10
`define ITA_DIR_BIT          4
`define ITA_SEL_HI           3
`define ITA_SEL_LO           2
`define ITA_AHI_HI           1
`define ITA_AHI_LO           0
`define ITA_DATA_TOP_W       5
`define ITA_ENTRY_AW         10
`define ITA_MEM_AW           12
`define ITA_MEM_DEPTH        4096

// ****************************************************************
// Reset values
// ****************************************************************
`define ITA_RST_SELECT       5'h00
`define ITA_RST_ADDR_LOW     8'h00
`define ITA_RST_DATA_TOP     5'h00

`endif

// File: rtl/ita_entry_mem.sv
// Entry store holding bits 68 to 64 of every table entry, registered read.
`timescale 1ns/10ps
`include "ita_consts.svh"

module ita_entry_mem (
    input  wire logic                         clk_i,
    input  wire logic                         we_i,
    input  wire logic                         re_i,
    input  wire logic [`ITA_MEM_AW-1:0]       addr_i,
    input  wire logic [`ITA_DATA_TOP_W-1:0]   wdata_i,
    output logic      [`ITA_DATA_TOP_W-1:0]   rdata_o
);

    logic [`ITA_DATA_TOP_W-1:0] mem [0:`ITA_MEM_DEPTH-1];

    // Write port; contents are not reset, software must load before use
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    // Read data held in a register until the next read
    always_ff @(posedge clk_i) begin
        if (re_i) begin
            rdata_o <= mem[addr_i];
        end
    end

endmodule

// File: rtl/ita_pkg.sv
// Types shared by the indirect table access port.
package ita_pkg;

    // Access engine states, one-hot
    typedef enum logic [2:0] {
        ITA_ENG_IDLE  = 3'b001,
        ITA_ENG_READ  = 3'b010,
        ITA_ENG_WRITE = 3'b100
    } ita_eng_state_t;

    // Table selector encoding
    typedef enum logic [1:0] {
        ITA_TBL_STATIC  = 2'h0,
        ITA_TBL_VLAN    = 2'h1,
        ITA_TBL_DYNAMIC = 2'h2,
        ITA_TBL_MIB     = 2'h3
    } ita_table_t;

endpackage

// File: rtl/ita_top.sv
// Indirect table access port: Avalon-MM register slave and access engine.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "ita_consts.svh"

module ita_top
    import ita_pkg::*;
(
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_i,
    input  wire logic [`ITA_BUS_AW-1:0]   avs_address_i,
    input  wire logic                     avs_read_i,
    input  wire logic                     avs_write_i,
    input  wire logic [31:0]              avs_writedata_i,
    input  wire logic [3:0]               avs_byteenable_i,
    output logic      [31:0]              avs_readdata_o,
    output logic                          avs_waitrequest_o,
    output logic                          access_busy_o,
    output logic      [3:0]               table_onehot_o
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    // Only implemented bits are stored; the rest read as zero
    logic [4:0]                    ctrl_select;   // dir, selector, address high
    logic [7:0]                    addr_low;
    logic [`ITA_DATA_TOP_W-1:0]    data_top;
    ita_eng_state_t                eng_state;
    logic [`ITA_DATA_TOP_W-1:0]    mem_rdata;
    logic                          load_pending;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    // Register hit: index match with both byte-offset bits at zero
    function automatic logic hit(input logic [`ITA_BUS_AW-1:0] a, input logic [7:0] idx);
        hit = (a[`ITA_BUS_AW-1:2] == idx) && (a[1:0] == 2'h0);
    endfunction

    // One-hot table code; the counter table takes the remaining code
    function automatic logic [3:0] table_decode(input logic [1:0] sel);
        logic [3:0] r;
        r = 4'h0;
        case (sel)
            ITA_TBL_STATIC:  r = 4'h1;
            ITA_TBL_VLAN:    r = 4'h2;
            ITA_TBL_DYNAMIC: r = 4'h4;
            default:         r = 4'h8;
        endcase
        table_decode = r;
    endfunction

    // ****************************************************************
    // Bus-side strobes
    // ****************************************************************
    // Derived combinationally from the bus; every output stays registered
    logic bus_req;
    logic bus_take;
    logic wr_take;
    logic busy;
    logic start;
    logic [`ITA_MEM_AW-1:0] mem_addr;

    // Busy covers the engine and the data load that follows a read
    assign busy     = (eng_state != ITA_ENG_IDLE) || load_pending;
    assign bus_req  = avs_read_i || avs_write_i;
    // Completion edge: the master sees waitrequest low here
    assign bus_take = bus_req && !avs_waitrequest_o;
    // Only byte lane 0 carries register data; the other lanes are ignored
    assign wr_take  = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    // Transfer starts on the committed write of the low address byte
    assign start    = wr_take && hit(avs_address_i, `ITA_IDX_ADDR_LOW);   // see RULE7
    // Entry address: selector on top, high bits, then low byte
    assign mem_addr = {ctrl_select[`ITA_SEL_HI:`ITA_SEL_LO],             // see RULE2
                       ctrl_select[`ITA_AHI_HI:`ITA_AHI_LO],             // see RULE3
                       addr_low};                                        // see RULE4

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    // Waitrequest stays high while the engine works, so set-up registers never move mid-access
    // Each access costs at least two cycles: one to accept, one to answer
    // The master must hold its request while waitrequest is high
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if (bus_take) begin
            avs_waitrequest_o <= 1'b1;
        end else if (bus_req && !busy) begin
            avs_waitrequest_o <= 1'b0;
        end
    end

    // Read data captured in the cycle before completion; unmapped reads return zero
    // Reads are answered from registers, never from the table directly
    // Status read is held off while busy, so its busy bit always reads zero
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h00000000;
        end else if (avs_read_i && avs_waitrequest_o && !busy) begin
            if (hit(avs_address_i, `ITA_IDX_CTRL_SELECT)) begin
                avs_readdata_o <= {24'h000000, 3'h0, ctrl_select};       // see RULE6
            end else if (hit(avs_address_i, `ITA_IDX_ADDR_LOW)) begin
                avs_readdata_o <= {24'h000000, addr_low};                // see RULE4
            end else if (hit(avs_address_i, `ITA_IDX_DATA_TOP)) begin
                avs_readdata_o <= {27'h0000000, data_top};               // see RULE5
            end else if (hit(avs_address_i, `ITA_IDX_STATUS)) begin
                avs_readdata_o <= {31'h00000000, busy};
            end else begin
                avs_readdata_o <= 32'h00000000;
            end
        end
    end

    // ****************************************************************
    // Set-up registers
    // ****************************************************************
    // Select register: reserved bits 7 to 5 are not stored
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_select <= `ITA_RST_SELECT;
        end else if (wr_take && hit(avs_address_i, `ITA_IDX_CTRL_SELECT)) begin
            ctrl_select <= avs_writedata_i[4:0];                         // see RULE6
        end
    end

    // Low address: writing it is what launches the access
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            addr_low <= `ITA_RST_ADDR_LOW;
        end else if (start) begin
            addr_low <= avs_writedata_i[7:0];                            // see RULE4
        end
    end

    // Top data: written by software, or loaded from the table after a read access
    // The load cannot collide with a bus write: the bus is stalled while busy
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            data_top <= `ITA_RST_DATA_TOP;
        end else if (load_pending) begin
            data_top <= mem_rdata;                                       // see RULE5
        end else if (wr_take && hit(avs_address_i, `ITA_IDX_DATA_TOP)) begin
            data_top <= avs_writedata_i[`ITA_DATA_TOP_W-1:0];            // see RULE5
        end
    end

    // ****************************************************************
    // Access engine
    // ****************************************************************
    // Direction is taken from the select register as it stands at the start
    // READ and WRITE each last one cycle; the table access itself takes one clock
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            eng_state <= ITA_ENG_IDLE;
        end else begin
            case (eng_state)
                ITA_ENG_IDLE: begin
                    if (start) begin
                        if (ctrl_select[`ITA_DIR_BIT]) begin             // see RULE1
                            eng_state <= ITA_ENG_READ;
                        end else begin
                            eng_state <= ITA_ENG_WRITE;
                        end
                    end
                end
                ITA_ENG_READ: begin
                    eng_state <= ITA_ENG_IDLE;
                end
                ITA_ENG_WRITE: begin
                    eng_state <= ITA_ENG_IDLE;
                end
                // Codes outside the one-hot set fall back to idle
                default: begin
                    eng_state <= ITA_ENG_IDLE;
                end
            endcase
        end
    end

    // Memory read data arrive one cycle after the read strobe
    // Without this stage the top data would catch the previous read result
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            load_pending <= 1'b0;
        end else begin
            load_pending <= (eng_state == ITA_ENG_READ);
        end
    end

    // ****************************************************************
    // Status outputs
    // ****************************************************************
    // Busy rises on the start edge itself, so the flag never lags the access
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            access_busy_o <= 1'b0;
        end else begin
            access_busy_o <= start || (eng_state != ITA_ENG_IDLE);      // see RULE7
        end
    end

    // Table code held for the whole access, cleared once the engine is idle and no data load is pending
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            table_onehot_o <= 4'h0;
        end else if (start) begin
            table_onehot_o <= table_decode(ctrl_select[`ITA_SEL_HI:`ITA_SEL_LO]); // see RULE2
        end else if (!busy) begin
            table_onehot_o <= 4'h0;
        end
    end

    // ****************************************************************
    // Entry store
    // ****************************************************************
    // Selector forms the top address bits, so the tables never alias
    // Only entry bits 68 to 64 live here; the other data registers are elsewhere
    ita_entry_mem u_mem (
        .clk_i   (sys_clk_i),
        .we_i    (eng_state == ITA_ENG_WRITE),                           // see RULE1
        .re_i    (eng_state == ITA_ENG_READ),                            // see RULE1
        .addr_i  (mem_addr),
        .wdata_i (data_top),
        .rdata_o (mem_rdata)
    );

endmodule

// File: sim/ita_monitor.sv
// Checker for the indirect table access port, bound to its top ports.
`timescale 1ns/10ps
module ita_monitor
    import ita_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic [9:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    input  wire logic [31:0] avs_readdata_o,
    input  wire logic        avs_waitrequest_o,
    input  wire logic        access_busy_o,
    input  wire logic [3:0]  table_onehot_o
);
    // ********
    // Shadow state
    // ********
    logic [4:0] sel_q;
    logic [7:0] low_q;
    wire wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
    wire rd_done = avs_read_i && !avs_waitrequest_o;

    // Shadow of the select byte, bits 4 to 0 only
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sel_q <= 5'h00;
        end else if (wr_done && avs_address_i == 10'h1B8) begin
            sel_q <= avs_writedata_i[4:0];
        end
    end

    // Shadow of the low address byte
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            low_q <= 8'h00;
        end else if (wr_done && avs_address_i == 10'h1BC) begin
            low_q <= avs_writedata_i[7:0];
        end
    end

    // ********
    // Properties
    // ********
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Onehot may trail busy by a cycle, so only settled busy cycles are judged
    a_sel_route: assert property (
        access_busy_o && $past(access_busy_o) |-> table_onehot_o == (4'h1 << sel_q[3:2]))
        else $error("table onehot does not follow selector");
    a_idle_none: assert property (
        !access_busy_o && !$past(access_busy_o) |-> table_onehot_o == 4'h0)
        else $error("table onehot set while idle");
    a_resv_zero: assert property (
        rd_done && avs_address_i == 10'h1B8 |-> avs_readdata_o[7:5] == 3'h0)
        else $error("reserved select bits not zero");
    a_high_back: assert property (
        rd_done && avs_address_i == 10'h1B8 |-> avs_readdata_o[4:0] == sel_q)
        else $error("select readback wrong");
    a_low_back: assert property (
        rd_done && avs_address_i == 10'h1BC |-> avs_readdata_o[7:0] == low_q)
        else $error("low address readback wrong");
    a_top_width: assert property (
        rd_done && avs_address_i == 10'h1C0 |-> avs_readdata_o[31:5] == 27'h0)
        else $error("top data wider than five bits");
    a_start_busy: assert property (
        wr_done && avs_address_i == 10'h1BC |-> ##[1:2] access_busy_o)
        else $error("low address write did not start access");
    a_no_start: assert property (
        wr_done && avs_address_i != 10'h1BC && !access_busy_o |=> !access_busy_o)
        else $error("access started by another register");
    a_busy_hold: assert property (
        access_busy_o |-> avs_waitrequest_o)
        else $error("bus answered during access");
    a_busy_short: assert property (
        $rose(access_busy_o) |-> ##[1:4] !access_busy_o)
        else $error("access never finished");

    c_top_read: cover property (rd_done && avs_address_i == 10'h1C0);
    c_counters: cover property (table_onehot_o == 4'h8);
    c_unmapped: cover property (rd_done && avs_address_i == 10'h140);
endmodule

// File: sim/ita_top_tb_top.sv
// Self-checking bench for the indirect table access port.
`timescale 1ns/10ps
module ita_top_tb_top;
    import ita_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [9:0]  avs_address_i = 10'h000;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        access_busy_o;
    logic [3:0]  table_onehot_o;
    int          n_fail = 0;
    int          check_count = 0;
    int          cycles = 0;

    ita_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .access_busy_o(access_busy_o), .table_onehot_o(table_onehot_o));

    // ********
    // Bus tasks
    // ********
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request held until waitrequest is sampled low at an edge
    task automatic bus(input logic rd, input logic [7:0] idx, input logic [7:0] wd,
                       input logic be, output logic [31:0] q);
        @(posedge sys_clk_i);
        avs_address_i <= {idx, 2'b00};
        avs_read_i <= rd;
        avs_write_i <= !rd;
        avs_writedata_i <= {24'h0, wd};
        avs_byteenable_i <= {3'h0, be};
        @(posedge sys_clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge sys_clk_i);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic be);
        logic [31:0] q;
        bus(1'b0, idx, d, be, q);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b1, idx, 8'h00, 1'b1, q);
        chk(q, exp);
    endtask

    // Busy may rise a cycle late, so wait a little before polling it
    task automatic settle();
        repeat (2) @(posedge sys_clk_i);
        while (access_busy_o !== 1'b0) @(posedge sys_clk_i);
        repeat (2) @(posedge sys_clk_i);
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_reset();
        rdc(8'h6E, 32'h0);
        rdc(8'h6F, 32'h0);
        rdc(8'h70, 32'h0);
        rdc(8'h7E, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr(8'h6E, 8'hFF, 1'b1);
        rdc(8'h6E, 32'h1F);
        wr(8'h70, 8'hFF, 1'b1);
        rdc(8'h70, 32'h1F);
        wr(8'h70, 8'h00, 1'b0);
        rdc(8'h70, 32'h1F);
        wr(8'h50, 8'hFF, 1'b1);
        rdc(8'h50, 32'h0);
        $display("test regs done");
    endtask

    // Table and high address both vary, so ignoring either one aliases entries
    task automatic t_tables();
        logic [7:0] sel;
        for (int i = 0; i < 8; i++) begin
            sel = {4'h0, i[1:0], i[2] ? 2'b11 : 2'b00};
            wr(8'h70, 8'h09 + i[7:0], 1'b1);
            wr(8'h6E, sel, 1'b1);
            wr(8'h6F, 8'hA5, 1'b1);
            settle();
        end
        for (int i = 0; i < 8; i++) begin
            sel = {4'h1, i[1:0], i[2] ? 2'b11 : 2'b00};
            wr(8'h70, 8'h00, 1'b1);
            wr(8'h6E, sel, 1'b1);
            wr(8'h6F, 8'hA5, 1'b1);
            settle();
            rdc(8'h6F, 32'hA5);
            rdc(8'h70, {27'h0, 5'h09 + i[4:0]});
        end
        $display("test tables done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Clock and main sequence
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_tables();
        final_report();
    end

    // Cycle ceiling well above the few hundred cycles the tests need
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end
endmodule

bind ita_top ita_monitor u_mon (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .access_busy_o(access_busy_o), .table_onehot_o(table_onehot_o));
